/* core/iab_addr_baud.sv */
// module: address and baud register with wishbone slave and address comparison
// Function
// - master: scl period is four times (value+1)
// - 10-bit header: upper five bits fixed-compared
// - 10-bit header: address bits 9-8 from bits 2-1
// - 10-bit header match ignores lowest mask bit
// - 10-bit low byte compares all bits 7-0
// - register bit 0 ignored in 7-bit/header
`timescale 1ns/100ps
`default_nettype none
module iab_addr_baud #(
	parameter int DIV_W = 8  // width of the address / baud register
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  rxByte,
	input  wire logic        rxValid,
	input  wire logic        rxSecond,
	output logic             addrMatch,
	output logic             sclOut,
	output logic             sclEdge
);
	// software-visible state
	logic [DIV_W-1:0] addrBaud_ff;  // address / baud divider register
	logic [7:0]       mask_ff;      // address mask register
	logic [1:0]       mode_ff;      // operating mode
	logic             divEn_ff;     // divider enable
	logic [2:0]       matchSt_ff;   // sticky-free last match results
	logic             addrMatch_ff; // match pulse for the shifter
	logic             ack_ff;       // wishbone acknowledge
	logic [31:0]      rdData_ff;    // registered read data
	// comparison results and bus request decodes
	logic             hit7;         // 7-bit address hit
	logic             hit10h;       // 10-bit header hit
	logic             hit10l;       // 10-bit low byte hit
	logic             busReq;       // new wishbone request this cycle
	logic             wrLane0;      // write with low byte lane enabled

	// masked compare of selected bits
	// a cleared mask bit drops that bit from the compare
	function automatic logic maskedEq(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] m);
		maskedEq = ((a ^ b) & m) == 8'h00;
	endfunction

	// a request is new until the ack for it has been given
	assign busReq  = wb_cyc_i && wb_stb_i && !ack_ff;
	// only byte lane 0 carries register bits
	assign wrLane0 = busReq && wb_we_i && wb_sel_i[0];

	// 7-bit: received bits 7-1 against register 7-1, bit 0 left out
	assign hit7 = maskedEq(rxByte, 8'(addrBaud_ff), {mask_ff[7:1], 1'b0});
	// 10-bit header: fixed 11110 upper bits, register bits 2-1, bit 0 and mask bit 0 unused
	assign hit10h = (rxByte[7:3] == iab_pkg::TEN_BIT_HDR)
		&& maskedEq(rxByte, 8'(addrBaud_ff), {5'h00, mask_ff[2:1], 1'b0});
	// 10-bit low byte: whole register compared under full mask
	// bit 0 takes part here, unlike in the two other compares
	assign hit10l = maskedEq(rxByte, 8'(addrBaud_ff), mask_ff);

	// wishbone acknowledge: one cycle after request, dropped next cycle
	// busReq is masked during the ack cycle, so with ce high ack never stays high two cycles in a row
	always_ff @(posedge clk)
	begin
		if (rst)
			ack_ff <= 1'b0;
		else if (ce)
			ack_ff <= busReq;
	end

	// read data register
	always_ff @(posedge clk)
	begin
		if (rst)
			rdData_ff <= 32'h0000_0000;
		else if (ce && busReq)
		begin
			// each register reads zero-extended to the bus width
			case (wb_adr_i)
				iab_pkg::OFF_ADDR_BAUD: rdData_ff <= 32'(addrBaud_ff);
				iab_pkg::OFF_MASK:      rdData_ff <= {24'h000000, mask_ff};
				iab_pkg::OFF_CTRL:      rdData_ff <= {29'h0, divEn_ff, mode_ff};
				iab_pkg::OFF_STATUS:    rdData_ff <= {28'h0, sclOut, matchSt_ff};
				default:                rdData_ff <= 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// address / baud register write
	always_ff @(posedge clk)
	begin
		if (rst)
			addrBaud_ff <= DIV_W'(iab_pkg::RST_ADDR_BAUD);
		// only the low DIV_W bits of the data bus are kept
		else if (ce && wrLane0 && wb_adr_i == iab_pkg::OFF_ADDR_BAUD)
			addrBaud_ff <= wb_dat_i[DIV_W-1:0];
	end

	// mask register write
	// reset leaves every address bit compared
	always_ff @(posedge clk)
	begin
		if (rst)
			mask_ff <= iab_pkg::RST_MASK;
		else if (ce && wrLane0 && wb_adr_i == iab_pkg::OFF_MASK)
			mask_ff <= wb_dat_i[7:0];
	end

	// control register write
	// mode 3 is not decoded by the compare, so it never matches, and the divider stays off
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_ff  <= iab_pkg::RST_MODE;
			divEn_ff <= 1'b0;
		end
		else if (ce && wrLane0 && wb_adr_i == iab_pkg::OFF_CTRL)
		begin
			mode_ff  <= wb_dat_i[iab_pkg::CTRL_MODE_HI:iab_pkg::CTRL_MODE_LO];
			divEn_ff <= wb_dat_i[iab_pkg::CTRL_EN];
		end
	end

	// address compare on each received address byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			matchSt_ff   <= 3'h0;
			addrMatch_ff <= 1'b0;
		end
		else if (ce)
		begin
			// match is a pulse: cleared unless a byte hits
			addrMatch_ff <= 1'b0;
			if (rxValid)
			begin
				case (mode_ff)
					iab_pkg::MODE_SLV7:
					begin
						matchSt_ff   <= {2'b00, hit7};
						addrMatch_ff <= hit7;
					end
					iab_pkg::MODE_SLV10:
					begin
						// the shifter tells which byte of a 10-bit address this is
						if (rxSecond)
						begin
							matchSt_ff   <= {hit10l, 2'b00};
							addrMatch_ff <= hit10l;
						end
						else
						begin
							matchSt_ff   <= {1'b0, hit10h, 1'b0};
							addrMatch_ff <= hit10h;
						end
					end
					default:
					begin
						// master mode never matches
						matchSt_ff <= 3'h0;
					end
				endcase
			end
		end
	end

	// scl generator: runs only in master mode with enable set
	// it restarts from a parked-high clock whenever it is enabled
	iab_scl_divider #(
		.DIV_W(DIV_W)
	) uDiv (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.enable   (divEn_ff && mode_ff == iab_pkg::MODE_MASTER),
		.divider  (addrBaud_ff),
		.sclLevel (sclOut),
		.sclEdge  (sclEdge)
	);

	// outputs straight from flip-flops
	assign wb_ack_o  = ack_ff;
	assign wb_dat_o  = rdData_ff;
	assign addrMatch = addrMatch_ff;

	// checks: register bus handshake
	// ack is a single-cycle pulse while the clock is enabled
	chk_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
		(ce && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	// a request taken with the clock enabled is answered one cycle later
	chk_ack_follows_req: assert property (@(posedge clk) disable iff (rst)
		(ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");

	// checks: register contents
	// read data of the address / baud register is its value at the taking edge
	chk_read_addr: assert property (@(posedge clk) disable iff (rst)
		(ce && busReq && !wb_we_i && wb_adr_i == iab_pkg::OFF_ADDR_BAUD)
		|=> wb_dat_o == 32'($past(addrBaud_ff)))
		else $error("address register read wrong");

	// a low-lane write lands in the address / baud register
	chk_write_lands: assert property (@(posedge clk) disable iff (rst)
		(ce && wrLane0 && wb_adr_i == iab_pkg::OFF_ADDR_BAUD) |=> addrBaud_ff == $past(wb_dat_i[7:0]))
		else $error("address register write lost");

	// mask register writes land the same way
	chk_mask_lands: assert property (@(posedge clk) disable iff (rst)
		(ce && wrLane0 && wb_adr_i == iab_pkg::OFF_MASK) |=> mask_ff == $past(wb_dat_i[7:0]))
		else $error("mask register write lost");

	// a write with byte lane 0 off is acked but changes nothing
	chk_lane_off: assert property (@(posedge clk) disable iff (rst)
		(ce && busReq && wb_we_i && !wb_sel_i[0]) |=> $stable(addrBaud_ff) && $stable(mask_ff))
		else $error("write with lane 0 off changed a register");

	// clock enable low holds every register, the handshake and the divider
	chk_ce_freeze: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(addrBaud_ff) && $stable(mask_ff) && $stable(mode_ff)
		&& $stable(wb_ack_o) && $stable(addrMatch) && $stable(sclOut))
		else $error("state moved with clock enable low");

	// checks: address compare
	// 7-bit mode: bits 7-1 equal under the mask give a match
	chk_seven_bit_hit: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV7
		&& (((rxByte ^ addrBaud_ff) & mask_ff) >> 1) == 8'h00) |=> addrMatch)
		else $error("7-bit address not matched");

	// 7-bit mode: any unmasked difference in bits 7-1 refuses the byte
	chk_seven_bit_miss: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV7
		&& (((rxByte ^ addrBaud_ff) & mask_ff) >> 1) != 8'h00) |=> !addrMatch)
		else $error("7-bit address matched on mismatch");

	// 7-bit mode: register bit 0 has no say in the result
	chk_bit0_ignored: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV7 && rxByte[0] != addrBaud_ff[0]
		&& rxByte[7:1] == addrBaud_ff[7:1] && mask_ff[7:1] == 7'h7f) |=> addrMatch)
		else $error("bit 0 affected 7-bit match");

	// 10-bit header: the fixed upper pattern is compared in hardware
	chk_header_fixed: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV10 && !rxSecond
		&& rxByte[7:3] != 5'h1e) |=> !addrMatch)
		else $error("header matched without 11110");

	// 10-bit header: matching high bits give a match whatever the mask bit 0
	chk_header_hi_bits: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV10 && !rxSecond
		&& rxByte[7:3] == 5'h1e && rxByte[2:1] == addrBaud_ff[2:1]) |=> addrMatch)
		else $error("10-bit header not matched");

	// 10-bit header: differing high bits under the mask refuse the byte
	chk_header_hi_miss: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV10 && !rxSecond
		&& mask_ff[2:1] == 2'h3 && rxByte[2:1] != addrBaud_ff[2:1]) |=> !addrMatch)
		else $error("10-bit header matched on wrong high bits");

	// 10-bit low byte: any unmasked difference refuses the byte
	chk_low_byte_full: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV10 && rxSecond
		&& mask_ff == 8'hff && rxByte != addrBaud_ff) |=> !addrMatch)
		else $error("low byte matched on mismatch");

	// 10-bit low byte: all eight bits equal under the mask give a match
	chk_low_byte_hit: assert property (@(posedge clk) disable iff (rst)
		(ce && rxValid && mode_ff == iab_pkg::MODE_SLV10 && rxSecond
		&& ((rxByte ^ addrBaud_ff) & mask_ff) == 8'h00) |=> addrMatch)
		else $error("low byte not matched");

	// master mode never flags a match
	chk_master_no_match: assert property (@(posedge clk) disable iff (rst)
		(mode_ff == iab_pkg::MODE_MASTER) |=> !addrMatch)
		else $error("match raised in master mode");

	// checks: divided clock
	// with the divider off the clock line rests high
	chk_scl_parked: assert property (@(posedge clk) disable iff (rst)
		(ce && !(divEn_ff && mode_ff == iab_pkg::MODE_MASTER)) |=> sclOut)
		else $error("scl not parked high while divider off");

	// covers: main scenarios
	cover_match7: cover property (@(posedge clk) disable iff (rst)
		addrMatch && matchSt_ff[0]);
	cover_match10: cover property (@(posedge clk) disable iff (rst)
		matchSt_ff[1] ##[1:50] matchSt_ff[2]);
	cover_read: cover property (@(posedge clk) disable iff (rst) wb_ack_o && !wb_we_i);
	cover_write: cover property (@(posedge clk) disable iff (rst) wb_ack_o && wb_we_i);
endmodule
`default_nettype wire

/* core/iab_pkg.sv */
// package: register map, field positions, reset values and modes of the address/baud block
package iab_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [3:0] OFF_ADDR_BAUD = 4'h0;  // address / baud divider register
	localparam logic [3:0] OFF_MASK      = 4'h4;  // address mask register
	localparam logic [3:0] OFF_CTRL      = 4'h8;  // mode control register
	localparam logic [3:0] OFF_STATUS    = 4'hc;  // match status register
	// reset values
	localparam logic [7:0] RST_ADDR_BAUD = 8'h00; // address / baud clears to zero
	localparam logic [7:0] RST_MASK      = 8'hff; // every address bit compared
	localparam logic [1:0] RST_MODE      = 2'h0;  // master mode after reset
	// control field positions
	localparam int CTRL_MODE_LO = 0;  // mode field low bit
	localparam int CTRL_MODE_HI = 1;  // mode field high bit
	localparam int CTRL_EN      = 2;  // divider enable bit
	// status field positions
	localparam int ST_MATCH7  = 0;  // last byte matched a 7-bit address
	localparam int ST_MATCH10H = 1; // last byte matched a 10-bit header
	localparam int ST_MATCH10L = 2; // last byte matched a 10-bit low byte
	localparam int ST_SCL      = 3; // current divided clock level
	// fixed header pattern of a 10-bit first address byte
	localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
	// clock divider quarter-period multiplier
	localparam int QUARTERS = 4;
	// operating modes
	typedef enum logic [1:0]
	{
		MODE_MASTER = 2'h0,
		MODE_SLV7   = 2'h1,
		MODE_SLV10  = 2'h2
	} iab_mode_t;
endpackage

/* core/iab_scl_divider.sv */
// module: divider that turns the baud value into an scl clock level
`timescale 1ns/100ps
`default_nettype none
module iab_scl_divider #(
	parameter int DIV_W = 8  // width of the divider value
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             enable,
	input  wire logic [DIV_W-1:0] divider,
	output logic                  sclLevel,
	output logic                  sclEdge
);
	// half period is two quarters of (divider+1) system cycles
	logic [DIV_W+1:0] cnt_ff;     // cycles spent in current half period
	logic [DIV_W+1:0] halfLast;   // last count value of a half period
	logic             sclLevel_ff; // registered scl level
	logic             sclEdge_ff;  // registered toggle pulse

	// period = (divider + 1) * 4 cycles, so each half is 2*(divider+1)
	assign halfLast = (DIV_W+2)'(({2'h0, divider} + (DIV_W+2)'(1)) << 1) - (DIV_W+2)'(1);

	// counting and toggling process
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_ff      <= '0;
			sclLevel_ff <= 1'b1;
			sclEdge_ff  <= 1'b0;
		end
		else if (ce)
		begin
			sclEdge_ff <= 1'b0;
			if (!enable)
			begin
				// idle: clock parked high, count restarted
				cnt_ff      <= '0;
				sclLevel_ff <= 1'b1;
			end
			else if (cnt_ff >= halfLast)
			begin
				// half period done: toggle level
				cnt_ff      <= '0;
				sclLevel_ff <= ~sclLevel_ff;
				sclEdge_ff  <= 1'b1;
			end
			else
			begin
				cnt_ff <= cnt_ff + (DIV_W+2)'(1);
			end
		end
	end

	assign sclLevel = sclLevel_ff;
	assign sclEdge  = sclEdge_ff;

	// each half period lasts exactly 2*(divider+1) cycles
	chk_half_period_len: assert property (@(posedge clk) disable iff (rst)
		(ce && enable && cnt_ff >= halfLast)
		|=> (cnt_ff == '0) && sclEdge_ff && (sclLevel_ff != $past(sclLevel_ff)))
		else $error("divider half period did not end in a toggle");
	cover_toggle: cover property (@(posedge clk) disable iff (rst) sclEdge_ff);
endmodule
`default_nettype wire

/* testbench/iab_link_model.sv */
// far-side shifter model: hands received address bytes to the block
`timescale 1ns/100ps
`default_nettype none
module iab_link_model (
	input  wire logic clk,
	output logic [7:0] rxByte,
	output logic       rxValid,
	output logic       rxSecond
);
	// idle lines at time zero
	initial
	begin
		rxByte = 8'h00;
		rxValid = 1'b0;
		rxSecond = 1'b0;
	end
	// first byte of a 10-bit address: fixed pattern, top two bits, direction
	function automatic logic [7:0] hdr(input logic [1:0] hi, input logic rw);
		return {5'h1e, hi, rw};
	endfunction
	// one byte after gap+1 idle cycles; released data shows the inverse
	task automatic send(input logic [7:0] b, input logic sec, input int gap);
		@(posedge clk);
		repeat (gap) @(posedge clk);
		rxByte <= b;
		rxValid <= 1'b1;
		rxSecond <= sec;
		@(posedge clk);
		rxValid <= 1'b0;
		rxByte <= ~b;
		rxSecond <= ~sec;
	endtask
endmodule
`default_nettype wire

/* testbench/iab_addr_baud_bench.sv */
// testbench: wishbone access, divider timing and address compare
`timescale 1ns/100ps
`default_nettype none
module iab_addr_baud_bench;
	logic        clk, rst, ce, cyc, stb, we;
	logic [3:0]  adr, sel;
	logic [31:0] datW, datR, rd, seed;
	logic        ack, match, scl, sclEdge, rxValid, rxSecond;
	logic [7:0]  rxByte, a, b, m;
	logic        lv, ex;
	logic [3:0]  selV;
	int          fails, checked, cycles, n, d;
	// design and far-side model
	iab_addr_baud dut_u (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
		.wb_ack_o(ack), .rxByte(rxByte), .rxValid(rxValid), .rxSecond(rxSecond),
		.addrMatch(match), .sclOut(scl), .sclEdge(sclEdge));
	iab_link_model link_u (.clk(clk), .rxByte(rxByte), .rxValid(rxValid), .rxSecond(rxSecond));
	// 100 ns clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end
	// pseudo-random step
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected 7-bit hit: bits 7-1 compared under mask
	function automatic logic exp7(input logic [7:0] r, x, k);
		return (((r ^ x) & k & 8'hfe) == 8'h00);
	endfunction
	// expected header hit: fixed pattern, bits 2-1 under mask
	function automatic logic expHdr(input logic [7:0] r, x, k);
		return (x[7:3] == 5'h1e) && (((r ^ x) & k & 8'h06) == 8'h00);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// one classic wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dv);
		@(posedge clk);
		{cyc, stb, we, adr, sel, datW} <= {2'b11, w, ad, selV, dv};
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		rd = datR;
		{cyc, stb, we, adr, datW} <= {3'b000, ~ad, ~dv};
	endtask
	task automatic results();
		if (fails == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{rst, ce, cyc, stb, we, adr, sel, datW} = {2'b11, 3'b000, 4'h0, 4'h0, 32'h0};
		seed = 32'h00010df6;
		selV = 4'hf;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wb(0, iab_pkg::OFF_ADDR_BAUD, 0);
		chk("addrBaud reset", 32'h0, rd);
		wb(0, iab_pkg::OFF_MASK, 0);
		chk("mask reset", 32'hff, rd);
		wb(1, 4'h1, 32'h5a);
		wb(0, 4'h1, 0);
		chk("unmapped", 32'h0, rd);
		selV = 4'he;
		wb(1, iab_pkg::OFF_ADDR_BAUD, 32'h33);
		selV = 4'hf;
		wb(0, iab_pkg::OFF_ADDR_BAUD, 0);
		chk("lane0 off", 32'h0, rd);
		// divider: half-period check for zero, mid and random values
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			d = (i == 0) ? 0 : (i == 1) ? 3 : int'(seed[2:0]);
			wb(1, iab_pkg::OFF_ADDR_BAUD, d);
			wb(0, iab_pkg::OFF_ADDR_BAUD, 0);
			chk("addrBaud rw", d, rd);
			wb(1, iab_pkg::OFF_CTRL, 32'h04);
			n = 0;
			while (sclEdge !== 1'b1 && n < 40)
			begin
				@(posedge clk);
				#1 n++;
			end
			n = 0;
			do
			begin
				@(posedge clk);
				#1 n++;
			end while (sclEdge !== 1'b1 && n < 40);
			chk("half period", 2 * (d + 1), n);
			wb(0, iab_pkg::OFF_CTRL, 0);
			chk("ctrl rw", 32'h04, rd);
			@(posedge clk);
			ce <= 1'b0;
			#1 lv = scl;
			repeat (2 * (d + 1)) @(posedge clk);
			#1 chk("ce freeze", lv, scl);
			@(posedge clk);
			ce <= 1'b1;
			wb(1, iab_pkg::OFF_CTRL, 32'h00);
			#1 chk("scl idle", 1, scl);
		end
		link_u.send(8'h00, 0, 0);
		#1 chk("master no match", 0, match);
		// 7-bit and 10-bit compare with random bytes and masks
		for (int i = 0; i < 24; i++)
		begin
			seed = lfsr(seed);
			a = seed[7:0];
			m = seed[8] ? 8'hff : ~(8'h01 << seed[31:29]);
			b = seed[9] ? {a[7:1], seed[10]} : seed[18:11];
			wb(1, iab_pkg::OFF_ADDR_BAUD, a);
			wb(1, iab_pkg::OFF_MASK, m);
			wb(1, iab_pkg::OFF_CTRL, 32'h01);
			link_u.send(b, 0, seed[20:19]);
			#1 chk("match7", exp7(a, b, m), match);
			wb(1, iab_pkg::OFF_CTRL, 32'h02);
			b = link_u.hdr(seed[9] ? a[2:1] : seed[22:21], seed[23]);
			if (seed[24])
				b[7:3] = seed[29:25];
			link_u.send(b, 0, 0);
			#1 chk("matchHdr", expHdr(a, b, m), match);
			b = seed[9] ? a : seed[31:24];
			ex = ((a ^ b) & m) == 8'h00;
			link_u.send(b, 1, seed[20:19]);
			#1 chk("matchLow", ex, match);
			wb(0, iab_pkg::OFF_STATUS, 0);
			chk("status", {28'h0, 1'b1, ex, 2'b00}, rd);
		end
		// reset in mid-run brings every register back
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1 chk("rst scl", 1, scl);
		wb(0, iab_pkg::OFF_ADDR_BAUD, 0);
		chk("addrBaud after rst", 32'h0, rd);
		wb(0, iab_pkg::OFF_MASK, 0);
		chk("mask after rst", 32'hff, rd);
		wb(0, iab_pkg::OFF_CTRL, 0);
		chk("ctrl after rst", 32'h0, rd);
		results();
	end
endmodule
`default_nettype wire
